// ===== hw/rxpt_chan.v
`timescale 1ns/1ps
`include "rxpt_defs.vh"

module rxpt_chan (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire start,
    input wire enable,
    input wire check_ack,
    input wire ack,
    input wire [15:0] quanta,
    output reg req_q,
    output wire busy
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WACK = 4'b0010;
    localparam [3:0] ST_COUNT = 4'b0100;
    localparam [3:0] ST_WDROP = 4'b1000;

    reg [3:0] st_q;
    reg [3:0] st_d;
    reg [15:0] tmr_q;
    reg [15:0] tmr_d;
    reg [5:0] to_q;
    reg [5:0] to_d;
    reg req_d;

    assign busy = ~st_q[0];

    // one handshake per class; enable only gates entry from idle
    always @* begin
        st_d = st_q;
        tmr_d = tmr_q;
        to_d = to_q;
        req_d = req_q;
        case (st_q)
            ST_IDLE: begin
                if (start && enable) begin
                    req_d = 1'b1;
                    tmr_d = quanta;
                    st_d = check_ack ? ST_WACK : ST_COUNT;
                end
            end
            ST_WACK: begin
                if (start) begin
                    tmr_d = quanta;
                end else if (ack) begin
                    st_d = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (start) begin
                    tmr_d = quanta;
                end else if (tmr_q == 16'h0000) begin
                    req_d = 1'b0;
                    to_d = 6'h00;
                    st_d = check_ack ? ST_WDROP : ST_IDLE;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
            ST_WDROP: begin
                // a late pause frame restarts the count; ack is still high
                if (start) begin
                    req_d = 1'b1;
                    tmr_d = quanta;
                    st_d = ST_COUNT;
                end else if (!ack || to_q == `RXPT_ACK_TIMEOUT - 6'h01) begin
                    st_d = ST_IDLE;
                end else begin
                    to_d = to_q + 6'h01;
                end
            end
            default: begin
                st_d = ST_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    // state flops, frozen while the clock enable is low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            tmr_q <= 16'h0000;
            to_q <= 6'h00;
            req_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            to_q <= to_d;
            req_q <= req_d;
        end
    end

endmodule // rxpt_chan

// ===== hw/rxpt_top.v
`timescale 1ns/1ps
`include "rxpt_defs.vh"

module rxpt_top (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire [5:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire frm_valid,
    input wire [47:0] frm_da,
    input wire [47:0] frm_sa,
    input wire [15:0] frm_etype,
    input wire [15:0] frm_opcode,
    input wire [7:0] frm_cev,
    input wire [127:0] frm_quanta,
    output reg ctrl_fwd_q,
    output reg ctrl_term_q,
    output reg gpause_q,
    output reg ppause_q,
    input wire [8:0] pause_enable,
    input wire [8:0] pause_ack,
    output wire [8:0] pause_req
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    reg [31:0] cfg_q [0:`RXPT_NUM_CFG-1];
    wire [3:0] idx = paddr[5:2];
    wire acc = psel && penable;
    // misaligned writes are refused along with the error answer
    wire wr_fire = acc && pready && pwrite && (paddr[1:0] == 2'b00);
    wire [8:0] busy;

    // reset value of one configuration word
    function [31:0] cfg_rst;
        input integer i;
        begin
            case (i)
                0: cfg_rst = `RXPT_RST_CTRL;
                1: cfg_rst = `RXPT_RST_CHECK;
                4: cfg_rst = `RXPT_RST_MDA_LO;
                5: cfg_rst = `RXPT_RST_MDA_HI;
                8: cfg_rst = `RXPT_RST_ETYPE;
                9: cfg_rst = `RXPT_RST_ETYPE;
                10: cfg_rst = `RXPT_RST_OPC_GCP;
                11: cfg_rst = `RXPT_RST_OPC_PCP;
                12: cfg_rst = `RXPT_RST_OPC_PAU;
                default: cfg_rst = 32'h0000_0000;
            endcase
        end
    endfunction

    // writes land only on the edge where pready is sampled high
    genvar g;
    generate
        for (g = 0; g < `RXPT_NUM_CFG; g = g + 1) begin : g_cfg
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[g] <= cfg_rst(g);
                end else if (clk_en && wr_fire && idx == g) begin
                    cfg_q[g] <= pwdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer on the second access cycle

    wire mapped = (paddr[1:0] == 2'b00) && (idx <= `RXPT_IDX_STATUS);
    reg [31:0] rd_d;

    // read mux; status shows live channel activity
    always @* begin
        if (idx == `RXPT_IDX_STATUS) begin
            rd_d = {7'h00, busy, 7'h00, pause_req};
        end else if (mapped) begin
            rd_d = cfg_q[idx];
        end else begin
            rd_d = 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && !mapped;
            if (acc && !pready && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration fields

    wire fwd_ctrl = cfg_q[0][`RXPT_CTRL_FWD];
    wire check_ack = cfg_q[0][`RXPT_CTRL_CHKACK];
    wire [5:0] ck_gcp = cfg_q[1][`RXPT_GRP_GCP+5:`RXPT_GRP_GCP];
    wire [5:0] ck_pcp = cfg_q[1][`RXPT_GRP_PCP+5:`RXPT_GRP_PCP];
    wire [5:0] ck_gpp = cfg_q[1][`RXPT_GRP_GPP+5:`RXPT_GRP_GPP];
    wire [5:0] ck_ppp = cfg_q[1][`RXPT_GRP_PPP+5:`RXPT_GRP_PPP];
    wire [47:0] flow_unicast_dest_addr = {cfg_q[3][15:0], cfg_q[2]};
    wire [47:0] flow_multicast_dest_addr = {cfg_q[5][15:0], cfg_q[4]};
    wire [47:0] flow_source_addr = {cfg_q[7][15:0], cfg_q[6]};
    wire [15:0] et_gcp = cfg_q[8][15:0];
    wire [15:0] et_pcp = cfg_q[8][31:16];
    wire [15:0] et_gpp = cfg_q[9][15:0];
    wire [15:0] et_ppp = cfg_q[9][31:16];
    wire [15:0] opc_min_gcp = cfg_q[10][15:0];
    wire [15:0] opc_max_gcp = cfg_q[10][31:16];
    wire [15:0] opc_min_pcp = cfg_q[11][15:0];
    wire [15:0] opc_max_pcp = cfg_q[11][31:16];
    wire [15:0] opc_gpp = cfg_q[12][15:0];
    wire [15:0] opc_ppp = cfg_q[12][31:16];
    wire glob_ctrl_src_check = ck_gcp[`RXPT_CK_SA];

    ////////////////////////////////////////////////////////////////////////
    // frame classification

    // one check group: address, source, ethertype, opcode, enable
    function ctl_hit;
        input [5:0] c;
        input da_u;
        input da_m;
        input sa_e;
        input et_e;
        input op_ok;
        reg da_ok;
        begin
            da_ok = (!c[`RXPT_CK_MCAST] && !c[`RXPT_CK_UCAST]) ||
                (da_u && c[`RXPT_CK_UCAST]) || (da_m && c[`RXPT_CK_MCAST]);
            ctl_hit = da_ok && (!c[`RXPT_CK_SA] || sa_e) &&
                (!c[`RXPT_CK_ETYPE] || et_e) && (!c[`RXPT_CK_OPC] || op_ok) &&
                c[`RXPT_CK_EN];
        end
    endfunction

    wire da_uc = (frm_da == flow_unicast_dest_addr);
    wire da_fix = (frm_da == `RXPT_MCAST_FIXED);
    wire da_mc = (frm_da == flow_multicast_dest_addr);
    wire sa_eq = (frm_sa == flow_source_addr);

    // global control: fixed multicast, opcode range
    wire gcp = ctl_hit(ck_gcp, da_uc, da_fix, glob_ctrl_src_check ? sa_eq : 1'b1,
        frm_etype == et_gcp,
        frm_opcode >= opc_min_gcp && frm_opcode <= opc_max_gcp);

    // priority control: configurable multicast address
    wire pcp = ctl_hit(ck_pcp, da_uc, da_mc, sa_eq, frm_etype == et_pcp,
        frm_opcode >= opc_min_pcp && frm_opcode <= opc_max_pcp);

    wire is_ctrl = gcp || pcp;

    // pause checks use an exact opcode
    wire gpp = ctl_hit(ck_gpp, da_uc, da_fix, sa_eq, frm_etype == et_gpp,
        frm_opcode == opc_gpp);
    wire ppp = ctl_hit(ck_ppp, da_uc, da_mc, sa_eq, frm_etype == et_ppp,
        frm_opcode == opc_ppp);

    // ordered decision: priority only examined when global fails
    wire ctl_frm = frm_valid && is_ctrl;
    wire g_hit = ctl_frm && gpp;
    wire p_hit = ctl_frm && !gpp && ppp;

    // class start vector, bit 8 global, bits 7:0 priorities
    wire [8:0] start = g_hit ? 9'h100 : (p_hit ? {1'b0, frm_cev} : 9'h000);

    // classification strobes, one cycle after the frame strobe
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_fwd_q <= 1'b0;
            ctrl_term_q <= 1'b0;
            gpause_q <= 1'b0;
            ppause_q <= 1'b0;
        end else if (clk_en) begin
            ctrl_fwd_q <= ctl_frm && fwd_ctrl;
            ctrl_term_q <= ctl_frm && !fwd_ctrl;
            gpause_q <= g_hit;
            ppause_q <= p_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-class pause handshakes

    // separate channels keep one class's timer off another's request
    generate
        for (g = 0; g < `RXPT_NCLASS; g = g + 1) begin : g_ch
            wire [15:0] q_sel;
            if (g == 8) begin : g_glob
                assign q_sel = frm_quanta[15:0];
            end else begin : g_prio
                assign q_sel = frm_quanta[g*16 +: 16];
            end
            rxpt_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .start(start[g]),
                .enable(pause_enable[g]),
                .check_ack(check_ack),
                .ack(pause_ack[g]),
                .quanta(q_sel),
                .req_q(pause_req[g]),
                .busy(busy[g])
            );
        end
    endgenerate

endmodule // rxpt_top

// ===== inc/rxpt_defs.vh
`ifndef RXPT_DEFS_VH
`define RXPT_DEFS_VH

// register byte offsets
`define RXPT_OFF_CTRL 6'h00
`define RXPT_OFF_CHECK 6'h04
`define RXPT_OFF_UDA_LO 6'h08
`define RXPT_OFF_UDA_HI 6'h0C
`define RXPT_OFF_MDA_LO 6'h10
`define RXPT_OFF_MDA_HI 6'h14
`define RXPT_OFF_SA_LO 6'h18
`define RXPT_OFF_SA_HI 6'h1C
`define RXPT_OFF_ETYPE_CTL 6'h20
`define RXPT_OFF_ETYPE_PAU 6'h24
`define RXPT_OFF_OPC_GCP 6'h28
`define RXPT_OFF_OPC_PCP 6'h2C
`define RXPT_OFF_OPC_PAU 6'h30
`define RXPT_OFF_STATUS 6'h34
`define RXPT_NUM_CFG 13
`define RXPT_IDX_STATUS 4'hD

// control register fields
`define RXPT_CTRL_FWD 0
`define RXPT_CTRL_CHKACK 1
// check register group base bits
`define RXPT_GRP_GCP 0
`define RXPT_GRP_PCP 8
`define RXPT_GRP_GPP 16
`define RXPT_GRP_PPP 24
// bits within one check group
`define RXPT_CK_MCAST 0
`define RXPT_CK_UCAST 1
`define RXPT_CK_SA 2
`define RXPT_CK_ETYPE 3
`define RXPT_CK_OPC 4
`define RXPT_CK_EN 5

// reset values
`define RXPT_RST_CTRL 32'h0000_0002
`define RXPT_RST_CHECK 32'h3D3D_3D3D
`define RXPT_RST_MDA_LO 32'hC200_0001
`define RXPT_RST_MDA_HI 32'h0000_0180
`define RXPT_RST_ETYPE 32'h8808_8808
`define RXPT_RST_OPC_GCP 32'h0006_0001
`define RXPT_RST_OPC_PCP 32'h0101_0101
`define RXPT_RST_OPC_PAU 32'h0101_0001

// fixed multicast pause destination
`define RXPT_MCAST_FIXED 48'h0180C2000001
// cycles before a stuck acknowledge is given up on
`define RXPT_ACK_TIMEOUT 6'h20
`define RXPT_NCLASS 9

`endif

// ===== sim/rxpt_checker.sv
`timescale 1ns/1ps
module rxpt_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [5:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic [7:0] frm_cev,
    input logic ctrl_fwd_q,
    input logic ctrl_term_q,
    input logic gpause_q,
    input logic ppause_q,
    input logic [8:0] pause_enable,
    input logic [8:0] pause_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one wait cycle, then a single answer
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    ////////////////////////////////////////
    a_apb_wait: assert property (s_setup |=> s_answer)
        else $error("answer not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready && psel |->
        pslverr == (paddr > 6'h34 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_fwd_term: assert property (!(ctrl_fwd_q && ctrl_term_q))
        else $error("control frame both passed and dropped");
    a_pause_ctrl: assert property (gpause_q || ppause_q |-> ctrl_fwd_q || ctrl_term_q)
        else $error("pause without control frame");
    a_step_excl: assert property (!(gpause_q && ppause_q))
        else $error("global and priority pause together");
    a_glob_req: assert property (gpause_q && $past(pause_enable[8]) |-> pause_req[8])
        else $error("global request not raised");
    a_prio_req: assert property (ppause_q |-> (pause_req[7:0] & $past(pause_enable[7:0] & frm_cev))
        == $past(pause_enable[7:0] & frm_cev))
        else $error("priority request not raised");
    a_glob_cause: assert property ($rose(pause_req[8]) |-> gpause_q)
        else $error("global request without frame");
    a_prio_cause: assert property (|(pause_req[7:0] & ~$past(pause_req[7:0])) |-> ppause_q)
        else $error("priority request without frame");
    a_reload_hold: assert property ($fell(pause_req[8]) |-> !gpause_q)
        else $error("request dropped despite new pause frame");
endmodule // rxpt_checker

bind rxpt_top rxpt_checker i_rxpt_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .frm_cev(frm_cev),
    .ctrl_fwd_q(ctrl_fwd_q), .ctrl_term_q(ctrl_term_q), .gpause_q(gpause_q),
    .ppause_q(ppause_q), .pause_enable(pause_enable), .pause_req(pause_req));

// ===== sim/rxpt_top_tb.sv
`timescale 1ns/1ps
`include "rxpt_defs.vh"
module rxpt_top_tb;
    localparam logic [47:0] MC = `RXPT_MCAST_FIXED;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frm_valid = 0, stuck = 0;
    logic [5:0] paddr = 6'h00;
    logic [31:0] pwdata = 32'h0, prdata, r32;
    logic pready, pslverr, fwd, term, gp, pp;
    logic [47:0] frm_da = 48'h0, frm_sa = 48'h0;
    logic [15:0] frm_etype = 16'h0, frm_opcode = 16'h0, q;
    logic [7:0] frm_cev = 8'h00, r, c;
    logic [127:0] frm_quanta = 128'h0;
    logic [8:0] pause_enable = 9'h000, pause_ack, pause_req;
    logic [3:0] dly = 4'h1;
    logic [32:0] rq[$];
    logic [3:0] sq[$];
    logic [5:0] ra[10] = '{6'h00, 6'h04, 6'h10, 6'h14, 6'h20, 6'h28, 6'h2C, 6'h30, 6'h34, 6'h38};
    logic [32:0] rv[10] = '{33'h2, 33'h3D3D3D3D, 33'hC2000001, 33'h180, 33'h88088808,
        33'h60001, 33'h1010101, 33'h1010001, 33'h0, 33'h100000000};
    // etype, opcode, expected strobes {pass, drop, global, priority}
    logic [35:0] ft[6] = '{36'h880800000, 36'h880800016, 36'h880800064, 36'h880800070,
        36'h880801015, 36'h080000010};
    int num_errors = 0, n_compared = 0, n;

    rxpt_top i_rxpt_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid), .frm_da(frm_da),
        .frm_sa(frm_sa), .frm_etype(frm_etype), .frm_opcode(frm_opcode), .frm_cev(frm_cev),
        .frm_quanta(frm_quanta), .ctrl_fwd_q(fwd), .ctrl_term_q(term), .gpause_q(gp),
        .ppause_q(pp), .pause_enable(pause_enable), .pause_ack(pause_ack),
        .pause_req(pause_req));
    rxpt_user_model i_rxpt_user_model (.pclk(pclk), .presetn(presetn), .pause_req(pause_req),
        .dly(dly), .stuck(stuck), .pause_ack(pause_ack));

    initial forever #12.5 pclk = ~pclk;
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic err(input string m);
        num_errors++;
        $display("Error %0t: %s", $time, m);
    endtask
    task automatic cmp_rd(input logic [32:0] g);
        n_compared++;
        if (rq.size() == 0 || g !== rq.pop_front())
            err("read answer mismatch");
    endtask
    task automatic cmp_strb(input logic [3:0] g);
        n_compared++;
        if (sq.size() == 0 || g !== sq.pop_front())
            err("frame strobe mismatch");
    endtask
    task automatic cmp_bit(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1)
            err(m);
    endtask
    // apb master: hold the request until pready, then one idle cycle
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err("no pready");
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // one header pulse; returns at the edge that takes it
    task automatic fr(input logic [47:0] da, input logic [15:0] et, input logic [15:0] op,
        input logic [7:0] cv, input logic [15:0] qn, input logic [3:0] ex);
        if (ex != 4'h0)
            sq.push_back(ex);
        @(posedge pclk);
        frm_da <= da;
        frm_etype <= et;
        frm_opcode <= op;
        frm_cev <= cv;
        frm_quanta <= {8{qn}};
        frm_valid <= 1'b1;
        @(posedge pclk);
        frm_valid <= 1'b0;
    endtask
    // cycles that one class request stays high
    task automatic meas(input int i);
        #1;
        n = 0;
        while (pause_req[i] === 1'b1 && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 300) begin
            err("request never dropped");
            wrap_up();
        end
    endtask
    ////////////////////////////////////////
    // scoreboard: oldest note against each answer or strobe
    always @(posedge pclk) begin
        // gated by reset so unknowns before the first reset edge are not taken
        if (presetn && pready === 1'b1 && pwrite === 1'b0)
            cmp_rd({pslverr, prdata});
        if (presetn && {fwd, term, gp, pp} !== 4'h0)
            cmp_strb({fwd, term, gp, pp});
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err("run timeout");
        wrap_up();
    end
    initial begin
        void'($urandom(2));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        r32 = $urandom & 32'h7FFFFFFF;
        apb(1'b1, 6'h08, r32);
        apb(1'b1, 6'h34, r32);
        rd(6'h08, {1'b0, r32});
        rd(6'h34, 33'h0);
        // all classes disabled: frames classify but no request starts
        foreach (ft[i]) fr(MC, ft[i][35:20], ft[i][19:4], 8'hFF, 16'h3, ft[i][3:0]);
        #1 cmp_bit(pause_req === 9'h000, "disabled class left idle");
        apb(1'b1, 6'h10, r32);
        fr({16'h0180, r32}, 16'h8808, 16'h0101, 8'h00, 16'h0, 4'h5);
        fr(MC, 16'h8808, 16'h0101, 8'h00, 16'h0, 4'h0);
        // forwarding on, no ack check; enable cleared mid-handshake
        apb(1'b1, 6'h00, 32'h1);
        pause_enable <= 9'h1FF;
        q = 16'($urandom_range(15));
        fr(MC, 16'h8808, 16'h0001, 8'h00, q, 4'hA);
        pause_enable <= 9'h0FF;
        meas(8);
        cmp_bit(n == q + 1, "request length");
        pause_enable <= 9'h1FF;
        fr(MC, 16'h8808, 16'h0001, 8'h00, 16'hA, 4'hA);
        repeat (4) @(posedge pclk);
        fr(MC, 16'h8808, 16'h0001, 8'h00, 16'hA, 4'hA);
        meas(8);
        cmp_bit(n >= 11, "timer not reloaded");
        r = 8'($urandom) | 8'h01;
        c = 8'($urandom) | 8'h01;
        pause_enable <= {1'b0, r};
        fr({16'h0180, r32}, 16'h8808, 16'h0101, c, 16'h5, 4'h9);
        #1 cmp_bit(pause_req === {1'b0, c & r}, "priority classes");
        meas(0);
        cmp_bit(n == 6, "priority length");
        // ack checking on, slow ack holds the timer
        apb(1'b1, 6'h00, 32'h2);
        dly <= 4'h8;
        pause_enable <= 9'h1FF;
        fr(MC, 16'h8808, 16'h0001, 8'h00, 16'h0, 4'h6);
        meas(8);
        cmp_bit(n >= 10, "timer ran before ack");
        repeat (12) @(posedge pclk);
        rd(6'h34, 33'h0);
        // ack never lowered: handshake gives up after 32 cycles
        dly <= 4'h1;
        stuck <= 1'b1;
        fr(MC, 16'h8808, 16'h0001, 8'h00, 16'h0, 4'h6);
        meas(8);
        rd(6'h34, 33'h1000000);
        repeat (20) @(posedge pclk);
        rd(6'h34, 33'h1000000);
        repeat (10) @(posedge pclk);
        rd(6'h34, 33'h0);
        stuck <= 1'b0;
        // unicast address check on, then a source address that must not match
        apb(1'b1, 6'h04, 32'h3D3D3D3F);
        fr({16'h0000, r32}, 16'h8808, 16'h0001, 8'h00, 16'h0, 4'h4);
        frm_sa <= 48'h1;
        fr(MC, 16'h8808, 16'h0001, 8'h00, 16'h0, 4'h0);
        repeat (4) @(posedge pclk);
        cmp_bit(rq.size() == 0 && sq.size() == 0, "notes left over");
        wrap_up();
    end
endmodule // rxpt_top_tb

// ===== sim/rxpt_user_model.sv
`timescale 1ns/1ps
module rxpt_user_model (
    input logic pclk,
    input logic presetn,
    input logic [8:0] pause_req,
    input logic [3:0] dly,
    input logic stuck,
    output logic [8:0] pause_ack
);
    logic [3:0] cnt_q [9];
    ////////////////////////////////////////
    // ack follows each request dly+1 cycles later; stuck never lowers it
    always @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < 9; i++) begin
            if (!presetn) begin
                cnt_q[i] <= 4'h0;
                pause_ack[i] <= 1'b0;
            end else if (pause_req[i] == pause_ack[i] || (stuck && pause_ack[i])) begin
                cnt_q[i] <= 4'h0;
            end else if (cnt_q[i] >= dly) begin
                pause_ack[i] <= pause_req[i];
                cnt_q[i] <= 4'h0;
            end else begin
                cnt_q[i] <= cnt_q[i] + 4'h1;
            end
        end
    end
endmodule // rxpt_user_model
